//--- hdl/bac_bridge_cfg.sv
// configuration bank: arbiter groups, error-report disables, clock gating
// Notes on behaviour
// - ten-bit group field, requesters low, bridge top
// - bit 0 low group, 1 high group
// - reset puts only bridge in high group
// - reserved priority and disable bits read zero
// - error reported only if unmasked and enabled
// - bit 1 masks posted write parity error
// - bit 2 masks posted write nondelivery
// - bits 3,4 mask target/master abort
// - bit 5 masks delayed write nondelivery
// - bit 6 masks delayed read no data
// - clocks 0-3 stop only when both bits set
// - secondary reset clears two-bit gating fields
// - clock 4 single bit, cleared on reset
// - reserved gating bits 13:9 read ones, bits 31:14 read zero, unwritable
`default_nettype none
module bac_bridge_cfg (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_dword,
  input wire logic [3:0] cfg_be_n,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic sec_bus_rst,
  input wire logic serr_enable,
  input wire logic [5:0] err_event,
  output logic serr_req,
  input wire logic sec_clk_src,
  output logic [4:0] sec_clk,
  output logic [9:0] prio_high
);
  logic [9:0] arb_ff;
  logic [9:0] nxt_arb;
  logic [5:0] dis_ff;
  logic [5:0] nxt_dis;
  logic [8:0] clk_ff;
  logic [8:0] nxt_clk;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic ack_ff;
  logic nxt_ack;
  logic [3:0] be;
  logic hit_arb;
  logic hit_err;
  logic hit_clk;

  bac_cfg_if cfg ();

  assign be = ~cfg_be_n;
  assign hit_arb = (cfg_dword == bac_pkg::ARB_DWORD);
  assign hit_err = (cfg_dword == bac_pkg::ERR_DWORD);
  assign hit_clk = (cfg_dword == bac_pkg::CLK_DWORD);

  always_comb begin
    nxt_arb = arb_ff;
    nxt_dis = dis_ff;
    nxt_clk = clk_ff;
    if (cfg_wr && hit_arb) begin
      // field spans bytes 2 and 3
      if (be[2]) begin
        nxt_arb[7:0] = cfg_wdata[bac_pkg::ARB_LSB +: 8];
      end
      if (be[3]) begin
        nxt_arb[9:8] = cfg_wdata[bac_pkg::ARB_LSB + 8 +: 2];
      end
    end
    if (cfg_wr && hit_err && be[0]) begin
      nxt_dis = cfg_wdata[bac_pkg::ERR_LSB +: bac_pkg::ERR_W];
    end
    if (cfg_wr && hit_clk) begin
      if (be[0]) begin
        nxt_clk[7:0] = cfg_wdata[7:0];
      end
      // only bit 8 of byte 1 is writable
      if (be[1]) begin
        nxt_clk[8] = cfg_wdata[8];
      end
    end
    // secondary reset wins over a write
    if (sec_bus_rst) begin
      nxt_clk = bac_pkg::CLK_RESET;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    nxt_ack = cfg_wr | cfg_rd;
    if (cfg_rd) begin
      if (hit_arb) begin
        nxt_rdata[bac_pkg::ARB_LSB +: bac_pkg::ARB_W] = arb_ff;
      end
      if (hit_err) begin
        nxt_rdata[bac_pkg::ERR_LSB +: bac_pkg::ERR_W] = dis_ff;
      end
      if (hit_clk) begin
        nxt_rdata[8:0] = clk_ff;
        nxt_rdata[bac_pkg::CLK_RSV_LSB +: 5] = bac_pkg::CLK_RSV_VAL;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      arb_ff <= bac_pkg::ARB_RESET;
      dis_ff <= bac_pkg::ERR_RESET;
      clk_ff <= bac_pkg::CLK_RESET;
      rdata_ff <= '0;
      ack_ff <= 1'b0;
    end else begin
      arb_ff <= nxt_arb;
      dis_ff <= nxt_dis;
      clk_ff <= nxt_clk;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
    end
  end

  // a set bit means high priority group
  assign prio_high = arb_ff;
  assign cfg.err_dis = dis_ff;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pair
      // stop only when both bits are one
      assign cfg.clk_stop[g] = &clk_ff[2*g +: 2];
    end
  endgenerate
  assign cfg.clk_stop[4] = clk_ff[8];

  bac_serr_gate u_serr (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .cfg(cfg.serr),
    .serr_enable(serr_enable),
    .err_event(err_event),
    .serr_req(serr_req)
  );

  bac_clk_gate #(
    .NUM(bac_pkg::CLK_NUM)
  ) u_clk (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .cfg(cfg.clkg),
    .clk_src(sec_clk_src),
    .sec_clk(sec_clk)
  );

  assign cfg_rdata = rdata_ff;
  assign cfg_ack = ack_ff;
endmodule : bac_bridge_cfg
`default_nettype wire

//--- hdl/bac_pkg.sv
// constants for the bridge arbitration, error-mask and clock-gating registers
`default_nettype none
package bac_pkg;
  // configuration dword addresses
  localparam logic [7:0] ARB_DWORD = 8'h40;
  localparam logic [7:0] ARB_OFFSET = 8'h42;
  localparam logic [7:0] ERR_DWORD = 8'h64;
  localparam logic [7:0] CLK_DWORD = 8'h68;
  // priority group field
  localparam int ARB_LSB = 16;
  localparam int ARB_W = 10;
  localparam logic [9:0] ARB_RESET = 10'h200;
  // error-report disable field, bits 6:1 of its dword
  localparam int ERR_LSB = 1;
  localparam int ERR_W = 6;
  localparam logic [5:0] ERR_RESET = 6'h00;
  // clock gating field, bits 8:0 of its dword
  localparam int CLK_W = 9;
  localparam int CLK_NUM = 5;
  localparam logic [8:0] CLK_RESET = 9'h000;
  localparam int CLK_RSV_LSB = 9;
  localparam logic [4:0] CLK_RSV_VAL = 5'h1f;
endpackage : bac_pkg
`default_nettype wire

//--- hdl/bac_cfg_if.sv
// carrier for register fields handed from the bank to the gating modules
`default_nettype none
interface bac_cfg_if;
  logic [5:0] err_dis;
  logic [4:0] clk_stop;
  modport bank (output err_dis, output clk_stop);
  modport serr (input err_dis);
  modport clkg (input clk_stop);
endinterface : bac_cfg_if
`default_nettype wire

//--- hdl/bac_serr_gate.sv
// masks error events onto the primary system-error request
`default_nettype none
module bac_serr_gate (
  input wire logic sys_clk,
  input wire logic resetn,
  bac_cfg_if.serr cfg,
  input wire logic serr_enable,
  input wire logic [5:0] err_event,
  output logic serr_req
);
  logic serr_ff;
  logic nxt_serr;

  always_comb begin
    nxt_serr = serr_enable & (|(err_event & ~cfg.err_dis));
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      serr_ff <= 1'b0;
    end else begin
      serr_ff <= nxt_serr;
    end
  end

  assign serr_req = serr_ff;
endmodule : bac_serr_gate
`default_nettype wire

//--- hdl/bac_clk_gate.sv
// glitch-free stop/run control of the secondary clock outputs
`default_nettype none
module bac_clk_gate #(
  parameter int NUM = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  bac_cfg_if.clkg cfg,
  input wire logic clk_src,
  output logic [NUM-1:0] sec_clk
);
  logic [NUM-1:0] stop_ff;
  logic [NUM-1:0] nxt_stop;
  logic [NUM-1:0] out_ff;
  logic [NUM-1:0] nxt_out;

  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : g_out
      always_comb begin
        nxt_stop[g] = clk_src ? cfg.clk_stop[g] : stop_ff[g];
        // a stopped output is held high
        nxt_out[g] = clk_src | nxt_stop[g];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stop_ff <= '0;
      out_ff <= '1;
    end else begin
      stop_ff <= nxt_stop;
      out_ff <= nxt_out;
    end
  end

  assign sec_clk = out_ff;
endmodule : bac_clk_gate
`default_nettype wire

//--- verif/bac_asserts.sv
// port checks for the configuration bank
`default_nettype none
module bac_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_dword,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic serr_enable,
  input wire logic [5:0] err_event,
  input wire logic serr_req,
  input wire logic sec_clk_src,
  input wire logic [4:0] sec_clk,
  input wire logic [9:0] prio_high
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_prio_rst: assert property ($rose(resetn) |-> prio_high == 10'h200)
    else $error("bad group reset");
  a_prio_chg: assert property ($changed(prio_high) |-> $past(cfg_wr) || $past(cfg_wr, 2))
    else $error("groups changed alone");
  a_serr_off: assert property (!serr_enable |=> !serr_req)
    else $error("error report while off");
  a_serr_why: assert property (serr_req |-> $past(serr_enable && (|err_event)))
    else $error("error report without cause");
  a_clk_high: assert property (sec_clk_src |=> sec_clk == 5'h1f)
    else $error("clock low while source high");
  a_clk_fall: assert property (|($past(sec_clk) & ~sec_clk) |-> !$past(sec_clk_src))
    else $error("short clock pulse");
  a_rd_zero: assert property (cfg_ack && $past(cfg_rd && cfg_dword == 8'h64)
    |-> cfg_rdata[31:7] == 25'h0 && !cfg_rdata[0]) else $error("mask reserved set");
  a_rd_ones: assert property (cfg_ack && $past(cfg_rd && cfg_dword == 8'h68)
    |-> cfg_rdata[13:9] == 5'h1f) else $error("gating reserved clear");
endmodule : bac_asserts
bind bac_bridge_cfg bac_asserts u_chk (.sys_clk, .resetn, .cfg_wr, .cfg_rd, .cfg_dword,
  .cfg_rdata, .cfg_ack, .serr_enable, .err_event, .serr_req, .sec_clk_src, .sec_clk,
  .prio_high);
`default_nettype wire

//--- verif/bac_src_model.sv
// far-side source pattern for the secondary clocks
`default_nettype none
module bac_src_model (
  input wire logic sys_clk,
  input wire logic run,
  output logic sec_clk_src
);
  initial sec_clk_src = 1'b1;
  // parks high when idle, as a stopped clock would
  always @(negedge sys_clk) sec_clk_src <= run ? ~sec_clk_src : 1'b1;
endmodule : bac_src_model
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the configuration bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0, sec_bus_rst = 0, serr_enable = 0;
  logic run = 0, sec_clk_src, cfg_ack, serr_req;
  logic [7:0] cfg_dword = 0;
  logic [3:0] cfg_be_n = 0;
  logic [31:0] cfg_wdata = 0, cfg_rdata;
  logic [5:0] err_event = 0;
  logic [4:0] sec_clk, lows;
  logic [9:0] prio_high;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  bac_src_model u_src (.sys_clk, .run, .sec_clk_src);
  bac_bridge_cfg u_dut (.sys_clk, .resetn, .cfg_wr, .cfg_rd, .cfg_dword, .cfg_be_n,
    .cfg_wdata, .cfg_rdata, .cfg_ack, .sec_bus_rst, .serr_enable, .err_event, .serr_req,
    .sec_clk_src, .sec_clk, .prio_high);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // write stores v, read compares against v
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] v);
    @(negedge sys_clk);
    {cfg_wr, cfg_rd, cfg_dword, cfg_be_n, cfg_wdata} = {w, !w, a, b, w ? v : 32'h0};
    @(negedge sys_clk);
    {cfg_wr, cfg_rd} = 2'b00;
    chk(cfg_ack, 1'b1);
    if (!w) chk(cfg_rdata, v);
  endtask : acc
  task automatic ev(input logic [5:0] e, input logic exp);
    @(negedge sys_clk);
    err_event = e;
    @(negedge sys_clk);
    err_event = 6'h00;
    chk(serr_req, exp);
  endtask : ev
  // a bit set in lows means that output was seen running
  task automatic lowchk(input logic [4:0] exp);
    repeat (4) @(negedge sys_clk);
    lows = 5'h00;
    repeat (8) @(negedge sys_clk) lows |= ~sec_clk;
    chk(lows, exp);
  endtask : lowchk
  task automatic t_regs;
    acc(0, 8'h40, 4'h0, 32'h0200_0000);
    acc(1, 8'h40, 4'h3, 32'hffff_ffff);
    acc(0, 8'h40, 4'h0, 32'h03ff_0000);
    chk(prio_high, 32'h3ff);
    acc(1, 8'h40, 4'hb, 32'h0);
    acc(0, 8'h40, 4'h0, 32'h0300_0000);
    acc(1, 8'h50, 4'h0, 32'hffff_ffff);
    acc(0, 8'h50, 4'h0, 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_serr;
    serr_enable = 1;
    for (int k = 0; k < 6; k++) begin
      acc(1, 8'h64, 4'he, 32'h2 << k);
      ev(6'h1 << k, 0);
      ev(6'h3f ^ (6'h1 << k), 1);
    end
    acc(1, 8'h64, 4'h0, 32'hffff_ffff);
    acc(0, 8'h64, 4'h0, 32'h7e);
    acc(1, 8'h64, 4'h0, 32'h0);
    serr_enable = 0;
    ev(6'h3f, 0);
    $display("serr done");
  endtask : t_serr
  task automatic t_clk;
    run = 1;
    lowchk(5'h1f);
    acc(1, 8'h68, 4'h0, 32'hffff_ffff);
    acc(0, 8'h68, 4'h0, 32'h3fff);
    lowchk(5'h00);
    acc(1, 8'h68, 4'hc, 32'hb5);
    lowchk(5'h1b);
    acc(1, 8'h68, 4'hc, 32'h1ff);
    @(negedge sys_clk);
    sec_bus_rst = 1;
    @(negedge sys_clk);
    sec_bus_rst = 0;
    acc(0, 8'h68, 4'h0, 32'h3e00);
    lowchk(5'h1f);
    $display("clk done");
  endtask : t_clk
  initial begin
    repeat (12) @(negedge sys_clk);
    resetn = 1;
    t_regs;
    t_serr;
    t_clk;
    final_report;
  end
  // generous ceiling, the tests need well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
endmodule : testbench
`default_nettype wire
